// ===== mcba_adapter.sv
`timescale 1ns/1ps
module mcba_adapter (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // processor side
   input wire logic PROCESSOR_SELECT_ONE_N,
   input wire logic REGION_SELECT_ADDRESS_BIT,
   output logic PROCESSOR_WAIT_N,
   output logic PROCESSOR_EXTERNAL_BUS_CLOCK_EN,
   // card side
   input wire logic CARD_READY_N,
   output logic CARD_CHIP_ENABLE_N
);
   // synced pin levels
   logic sel_n_s;
   logic region_s;
   logic ready_n_s;

   // decoded access conditions
   logic select_active;
   logic card_region;
   logic card_access;
   logic in_access;
   logic in_tail;
   logic enter_access;
   logic leave_access;
   logic reselect;
   logic stretch_done;

   // access sequencer group
   mcba_pkg::mcba_state_t state_r;
   mcba_pkg::mcba_state_t state_nxt;

   // stretch counter group
   logic [mcba_pkg::STRETCH_W-1:0] cnt_r;
   logic [mcba_pkg::STRETCH_W-1:0] cnt_nxt;

   // card enable group
   logic ce_n_r;
   logic ce_n_nxt;

   // processor wait group
   logic wait_n_r;
   logic wait_n_nxt;

   // bus clock export group
   logic clk_en_r;
   logic clk_en_nxt;

   // pins cross in through two flops
   mcba_sync #(.RESET_VAL(1'b1)) u_sync_sel (
      .clk(CLK),
      .rst(RST),
      .d_in(PROCESSOR_SELECT_ONE_N),
      .q_out(sel_n_s)
   );
   mcba_sync #(.RESET_VAL(1'b0)) u_sync_region (
      .clk(CLK),
      .rst(RST),
      .d_in(REGION_SELECT_ADDRESS_BIT),
      .q_out(region_s)
   );
   mcba_sync #(.RESET_VAL(1'b1)) u_sync_ready (
      .clk(CLK),
      .rst(RST),
      .d_in(CARD_READY_N),
      .q_out(ready_n_s)
   );

   // select one low, address in the card half of the area
   assign select_active = !sel_n_s;
   assign card_region = !region_s;
   assign card_access = select_active && card_region;

   // sequencer position
   assign in_access = (state_r == mcba_pkg::ST_ACTIVE);
   assign in_tail = (state_r == mcba_pkg::ST_HOLD);

   // idle sees a card access begin
   assign enter_access = (state_r == mcba_pkg::ST_IDLE) && card_access;
   // select released, or address moved to the gpio region
   assign leave_access = in_access && !card_access;
   // processor returns while the enable is still stretched
   assign reselect = in_tail && card_access;
   // last stretch cycle spent with no reselect
   assign stretch_done = in_tail && !card_access && (cnt_r == '0);

   // access sequencer: idle, active access, stretched tail
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         mcba_pkg::ST_IDLE: begin
            if (enter_access) begin
               state_nxt = mcba_pkg::ST_ACTIVE;
            end
         end
         mcba_pkg::ST_ACTIVE: begin
            if (leave_access) begin
               state_nxt = mcba_pkg::ST_HOLD;
            end
         end
         mcba_pkg::ST_HOLD: begin
            // reselect wins over the end of the tail
            if (reselect) begin
               state_nxt = mcba_pkg::ST_ACTIVE;
            end else if (stretch_done) begin
               state_nxt = mcba_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = mcba_pkg::ST_IDLE;
         end
      endcase
      if (RST) begin
         state_nxt = mcba_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge CLK) begin
      state_r <= state_nxt;
   end

   // stretch counter: loaded on release, counts down in the tail
   always_comb begin
      cnt_nxt = cnt_r;
      case (state_r)
         mcba_pkg::ST_ACTIVE: begin
            // load so the tail lasts the stretch count
            if (leave_access) begin
               cnt_nxt =
                  mcba_pkg::STRETCH_W'(mcba_pkg::STRETCH_CYCLES - 1);
            end
         end
         mcba_pkg::ST_HOLD: begin
            if (!reselect && (cnt_r != '0)) begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: begin
            cnt_nxt = cnt_r;
         end
      endcase
      if (RST) begin
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge CLK) begin
      cnt_r <= cnt_nxt;
   end

   // card enable: low from access start to the end of the tail
   always_comb begin
      ce_n_nxt = 1'b1;
      case (state_r)
         mcba_pkg::ST_IDLE: begin
            if (enter_access) begin
               ce_n_nxt = 1'b0;
            end
         end
         mcba_pkg::ST_ACTIVE: begin
            ce_n_nxt = 1'b0;
         end
         mcba_pkg::ST_HOLD: begin
            // enable held low; processor keeps address meanwhile
            ce_n_nxt = stretch_done;
         end
         default: begin
            ce_n_nxt = 1'b1;
         end
      endcase
      if (RST) begin
         ce_n_nxt = mcba_pkg::CE_N_RESET;
      end
   end

   always_ff @(posedge CLK) begin
      ce_n_r <= ce_n_nxt;
   end

   // processor wait: follows card ready only during an access
   always_comb begin
      wait_n_nxt = mcba_pkg::WAIT_N_RESET;
      case (state_r)
         mcba_pkg::ST_ACTIVE: begin
            // card stretches the cycle
            wait_n_nxt = ready_n_s;
         end
         default: begin
            wait_n_nxt = mcba_pkg::WAIT_N_RESET;
         end
      endcase
      if (RST) begin
         wait_n_nxt = mcba_pkg::WAIT_N_RESET;
      end
   end

   always_ff @(posedge CLK) begin
      wait_n_r <= wait_n_nxt;
   end

   // bus clock export: gated off only while in reset
   always_comb begin
      clk_en_nxt = 1'b1;
      if (RST) begin
         clk_en_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      clk_en_r <= clk_en_nxt;
   end

   // every output straight from its register
   assign CARD_CHIP_ENABLE_N = ce_n_r;
   assign PROCESSOR_WAIT_N = wait_n_r;
   assign PROCESSOR_EXTERNAL_BUS_CLOCK_EN = clk_en_r;
endmodule

// ===== mcba_adapter_asserts.sv
`timescale 1ns/1ps
module mcba_chk (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PROCESSOR_SELECT_ONE_N,
   input wire logic REGION_SELECT_ADDRESS_BIT,
   input wire logic PROCESSOR_WAIT_N,
   input wire logic PROCESSOR_EXTERNAL_BUS_CLOCK_EN,
   input wire logic CARD_READY_N,
   input wire logic CARD_CHIP_ENABLE_N
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   AST_FALL: assert property ($fell(CARD_CHIP_ENABLE_N) |->
      !$past(PROCESSOR_SELECT_ONE_N, 3) &&
      !$past(REGION_SELECT_ADDRESS_BIT, 3)) else $error("bad enable");
   AST_HOLD: assert property ($rose(CARD_CHIP_ENABLE_N) |->
      $past(PROCESSOR_SELECT_ONE_N, 5)) else $error("short stretch");
   AST_WAIT: assert property (!PROCESSOR_WAIT_N |->
      !CARD_CHIP_ENABLE_N && !$past(CARD_READY_N, 3)) else $error("wait");
   AST_CLK: assert property (!$past(RST) |->
      PROCESSOR_EXTERNAL_BUS_CLOCK_EN) else $error("clock off");
   AST_RST: assert property ($past(RST) |->
      CARD_CHIP_ENABLE_N && PROCESSOR_WAIT_N) else $error("reset");
   // select released while enabled, then held high
   sequence s_release;
      ($rose(PROCESSOR_SELECT_ONE_N) && !CARD_CHIP_ENABLE_N) ##1
         PROCESSOR_SELECT_ONE_N [*2];
   endsequence
   // enable stays low through the tail, then releases
   sequence s_tail;
      !CARD_CHIP_ENABLE_N [*3] ##1 CARD_CHIP_ENABLE_N;
   endsequence
   AST_STRETCH: assert property (s_release |-> s_tail)
      else $error("stretch length");
endmodule
bind mcba_adapter mcba_chk chk (.*);

// ===== mcba_card.sv
`timescale 1ns/1ps
module mcba_card (
   input wire logic ce_n,
   input wire logic slow,
   output logic rdy_n
);
   // pull-up: ready high while deselected
   assign rdy_n = ~(slow & ~ce_n);
endmodule

// ===== mcba_pkg.sv
package mcba_pkg;
   // bus clock rate and its period
   localparam int CLK_FREQ_MHZ = 125;
   localparam int CLK_PERIOD_NS = 8;
   // nominal exported bus clock rate after boot
   localparam int BUS_CLK_DEFAULT_MHZ = 80;
   // extra cycles the card enable stays low after select releases
   localparam int STRETCH_CYCLES = 2;
   localparam int STRETCH_W = 2;
   // address bit that chooses the gpio port region
   localparam int REGION_BIT = 19;
   localparam logic [19:0] GPIO_REGION_OFFSET = 20'h80000;
   // reset levels
   localparam logic CE_N_RESET = 1'b1;
   localparam logic WAIT_N_RESET = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACTIVE,
      ST_HOLD
   } mcba_state_t;
endpackage

// ===== mcba_sync.sv
`timescale 1ns/1ps
module mcba_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // async level in, synced level out
   input wire logic d_in,
   output logic q_out
);
   logic meta_r;
   logic meta_nxt;
   logic q_r;
   logic q_nxt;

   always_comb begin
      meta_nxt = d_in;
      q_nxt = meta_r;
      if (rst) begin
         meta_nxt = RESET_VAL;
         q_nxt = RESET_VAL;
      end
   end

   always_ff @(posedge clk) begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
   end

   assign q_out = q_r;
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(n,e,a) begin n_compared++; if ((a)!==(e)) begin miscompares++; \
 $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module testbench;
   logic CLK = 0, RST = 1, sel_n = 1, bit19 = 0, slow = 0;
   logic wait_n, clk_en, rdy_n, ce_n;
   int miscompares = 0, n_compared = 0, cyc = 0;
   mcba_adapter uut (.CLK(CLK), .RST(RST), .PROCESSOR_SELECT_ONE_N(sel_n),
      .REGION_SELECT_ADDRESS_BIT(bit19), .PROCESSOR_WAIT_N(wait_n),
      .PROCESSOR_EXTERNAL_BUS_CLOCK_EN(clk_en), .CARD_READY_N(rdy_n),
      .CARD_CHIP_ENABLE_N(ce_n));
   mcba_card card (.ce_n(ce_n), .slow(slow), .rdy_n(rdy_n));
   initial forever #4 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc > 500) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_acc(logic b, logic s, int lo);
      int n;
      n = 0;
      @(posedge CLK) begin
         bit19 <= b;
         slow <= s;
         sel_n <= 0;
      end
      repeat (2) @(posedge CLK);
      #1 `CHK("ce_early", 1'b1, ce_n)
      @(posedge CLK) #1 `CHK("ce_on", b, ce_n)
      repeat (3) @(posedge CLK);
      #1 `CHK("wait", ~(s & ~b), wait_n)
      @(posedge CLK) sel_n <= 1;
      repeat (8) begin
         @(posedge CLK);
         #1 n += (ce_n === 1'b0);
      end
      `CHK("stretch", lo, n)
   endtask
   task automatic t_resel();
      int n;
      int m;
      n = 0;
      m = 0;
      @(posedge CLK) begin
         bit19 <= 0;
         slow <= 0;
         sel_n <= 0;
      end
      repeat (6) @(posedge CLK);
      @(posedge CLK) sel_n <= 1;
      repeat (2) @(posedge CLK);
      sel_n <= 0;
      repeat (8) begin
         @(posedge CLK);
         #1 n += (ce_n !== 1'b0);
      end
      `CHK("resel_ce", 0, n)
      @(posedge CLK) sel_n <= 1;
      repeat (8) begin
         @(posedge CLK);
         #1 m += (ce_n === 1'b0);
      end
      `CHK("resel_tail", mcba_pkg::STRETCH_CYCLES + 2, m)
   endtask
   initial begin
      repeat (3) @(posedge CLK);
      RST <= 0;
      @(posedge CLK) #1 `CHK("clk_en", 1'b1, clk_en)
      `CHK("ce_rst", 1'b1, ce_n)
      t_acc(0, 0, mcba_pkg::STRETCH_CYCLES + 2);
      t_acc(0, 1, mcba_pkg::STRETCH_CYCLES + 2);
      t_acc(1, 1, 0);
      t_resel();
      complete_run();
   end
endmodule
